// ===== core/sctc_regs.vh
// Register indices, field positions, reset values and codes for the six
// channel timer. Assumes a word-addressed Avalon-MM slave: byte address = 4 * index.
`ifndef SCTC_REGS_VH
`define SCTC_REGS_VH

// Register word indices
`define SCTC_REG_TSC 6'h00
`define SCTC_REG_COUNT_HI 6'h01
`define SCTC_REG_COUNT_LO 6'h02
`define SCTC_REG_LIMIT_HI 6'h03
`define SCTC_REG_LIMIT_LO 6'h04
`define SCTC_REG_CHAN_CTRL0 6'h05
`define SCTC_REG_CHAN_VAL0 6'h0B

// Timer control register fields
`define SCTC_TSC_OVF 7
`define SCTC_TSC_OVF_IE 6
`define SCTC_TSC_HALT 5
`define SCTC_TSC_CRST 4

// Channel control register fields
`define SCTC_CH_FLAG 7
`define SCTC_CH_IE 6
`define SCTC_CH_MSB 5
`define SCTC_CH_MSA 4
`define SCTC_CH_ELH 3
`define SCTC_CH_ELL 2
`define SCTC_CH_TOV 1
`define SCTC_CH_MAX 0

// Codes and reset values
`define SCTC_PS_EXT 3'h7
`define SCTC_PS_TOP 3'h6
`define SCTC_PRESC_ALL 6'h3F
`define SCTC_LIMIT_RST 16'hFFFF
`define SCTC_EL_OFF 2'h0
`define SCTC_EL_TOGGLE 2'h1
`define SCTC_EL_CLEAR 2'h2
`define SCTC_EL_SET 2'h3

`endif

// ===== core/sctc_sync.v
// Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes every bit is independent; no multi-bit coherence is implied.
`timescale 1ns/1ns
`default_nettype none

module sctc_sync #(
    parameter W = 7
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // Pins in, synchronised levels out
    input wire [W-1:0] async_i,
    output reg [W-1:0] sync_o
);

reg [W-1:0] meta;

always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        meta <= {W{1'b0}};
        sync_o <= {W{1'b0}};
    end else if (ce_i) begin
        meta <= async_i;
        sync_o <= meta;
    end
end

endmodule
`default_nettype wire

// ===== core/sctc_top.v
// Six channel 16-bit timer with prescaler, modulo limit and byte registers.
// Assumes an Avalon-MM master on clk_i and asynchronous pins on the link side.
`include "sctc_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module sctc_top (
    // Clock, reset, enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // Avalon-MM slave
    input wire [5:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    // External counter clock
    input wire ext_timer_clock_pin_i,
    output wire ext_clk_is_input_o,
    // Channel pins
    input wire [5:0] chan_pin_i,
    output wire [5:0] chan_pin_o,
    output wire [5:0] chan_pin_oe_n_o,
    output wire [5:0] chan_pin_timer_o,
    // Interrupt requests
    output wire ovf_irq_o,
    output wire [5:0] chan_irq_o
);

////////////////////////////////////////////////////////////////////////////////
// Bus slave: one wait cycle on every access, writes act at the completing edge, read data and read latches are taken at the first edge

reg ack;
wire req = avs_read_i | avs_write_i;
wire wr_go = avs_write_i & ack;
wire rd_go = avs_read_i & ack;
wire [7:0] wdat = avs_writedata_i[7:0];
reg [7:0] rd_mux;

assign avs_waitrequest_o = req & ~ack;

always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        ack <= 1'b0;
        avs_readdata_o <= 32'h00000000;
    end else if (ce_i) begin
        ack <= req & ~ack;
        if (avs_read_i & ~ack) begin
            avs_readdata_o <= {24'h000000, rd_mux};
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and counter clock selection

wire [6:0] pin_s;
reg ext_prev;
reg [2:0] clock_divider_select;
reg [5:0] presc;
reg counter_halt;

sctc_sync #(.W(7)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i({chan_pin_i, ext_timer_clock_pin_i}),
    .sync_o(pin_s)
);

wire [2:0] shamt = `SCTC_PS_TOP - clock_divider_select;
wire [5:0] presc_mask = `SCTC_PRESC_ALL >> shamt;
wire use_ext = (clock_divider_select == `SCTC_PS_EXT);
// Pin frequency must stay below half the bus rate, edges come from synced level
wire tick = use_ext ? (pin_s[0] & ~ext_prev) : ((presc & presc_mask) == presc_mask);

assign ext_clk_is_input_o = use_ext;

////////////////////////////////////////////////////////////////////////////////
// Main counter, limit and overflow flag

reg [15:0] cnt;
reg [15:0] limit;
reg limit_hold;
reg overflow_flag;
reg overflow_irq_enable;
reg ovf_arm;
reg [7:0] lo_buf;
reg lo_latched;

wire wr_tsc = wr_go & (avs_address_i == `SCTC_REG_TSC);
wire rd_tsc = rd_go & (avs_address_i == `SCTC_REG_TSC);
wire cnt_rst = wr_tsc & wdat[`SCTC_TSC_CRST];
wire run = ~counter_halt & tick;
wire ovf_evt = run & (cnt == limit);
wire ovf_set = ovf_evt & ~limit_hold;

assign ovf_irq_o = overflow_flag & overflow_irq_enable & ~limit_hold;

always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        ext_prev <= 1'b0;
        presc <= 6'h00;
        cnt <= 16'h0000;
        clock_divider_select <= 3'h0;
        counter_halt <= 1'b1;
        overflow_irq_enable <= 1'b0;
        overflow_flag <= 1'b0;
        ovf_arm <= 1'b0;
        limit <= `SCTC_LIMIT_RST;
        limit_hold <= 1'b0;
        lo_buf <= 8'h00;
        lo_latched <= 1'b0;
    end else if (ce_i) begin
        ext_prev <= pin_s[0];
        if (cnt_rst) begin
            // Counter, prescaler and low byte latch only; a halt in the same write keeps it at zero
            cnt <= 16'h0000;
            presc <= 6'h00;
            lo_latched <= 1'b0;
            lo_buf <= 8'h00;
        end else begin
            presc <= presc + 6'h01;
            if (run) begin
                cnt <= ovf_evt ? 16'h0000 : cnt + 16'h0001;
            end
            // Latch with the edge that captures the high byte, so both halves agree
            if (avs_read_i & ~ack & (avs_address_i == `SCTC_REG_COUNT_HI) & ~lo_latched) begin
                lo_buf <= cnt[7:0];
                lo_latched <= 1'b1;
            end else if (rd_go & (avs_address_i == `SCTC_REG_COUNT_LO)) begin
                lo_latched <= 1'b0;
            end
        end
        if (wr_tsc) begin
            overflow_irq_enable <= wdat[`SCTC_TSC_OVF_IE];
            counter_halt <= wdat[`SCTC_TSC_HALT];
            clock_divider_select <= wdat[2:0];
        end
        // A new overflow wins over the clear and voids a pending read
        if (ovf_set) begin
            overflow_flag <= 1'b1;
            ovf_arm <= 1'b0;
        end else begin
            if (wr_tsc & ~wdat[`SCTC_TSC_OVF] & ovf_arm) begin
                overflow_flag <= 1'b0;
            end
            if (rd_tsc & avs_readdata_o[`SCTC_TSC_OVF]) begin
                ovf_arm <= 1'b1;
            end else if (wr_tsc) begin
                ovf_arm <= 1'b0;
            end
        end
        if (wr_go & (avs_address_i == `SCTC_REG_LIMIT_HI)) begin
            limit[15:8] <= wdat;
            limit_hold <= 1'b1;
        end else if (wr_go & (avs_address_i == `SCTC_REG_LIMIT_LO)) begin
            limit[7:0] <= wdat;
            limit_hold <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Channels

wire [47:0] ctrl_all;
wire [95:0] val_all;
wire [5:0] msb_all;
wire [5:0] hold_all;

genvar i;
generate
    for (i = 0; i < 6; i = i + 1) begin : g_chan
        localparam EVEN = (i % 2 == 0);
        localparam P = i + 1 - 2 * (i % 2);
        localparam [5:0] A_CTRL = `SCTC_REG_CHAN_CTRL0 + i;
        localparam [5:0] A_HI = `SCTC_REG_CHAN_VAL0 + 2 * i;
        localparam [5:0] A_LO = `SCTC_REG_CHAN_VAL0 + 2 * i + 1;
        localparam [5:0] A_PLO = `SCTC_REG_CHAN_VAL0 + 2 * P + 1;

        reg chan_event_flag;
        reg chan_irq_enable;
        reg buffered_mode_bit;
        reg unbuffered_mode_bit;
        reg [1:0] edge_level;
        reg overflow_toggle_enable;
        reg full_duty_force;
        reg [15:0] val;
        reg cmp_hold;
        reg cap_hold;
        reg arm;
        reg out_lvl;
        reg pin_prev;
        reg sel_partner;
        reg partner_pending;

        // Odd partner of a buffered even channel is switched off
        wire dis = (i % 2 == 1) & msb_all[i - (i % 2)];
        wire el_on = (edge_level != `SCTC_EL_OFF);
        wire mode_cmp = buffered_mode_bit | unbuffered_mode_bit;
        wire capture_mode = ~mode_cmp & el_on & ~dis;
        wire compare_mode = mode_cmp & el_on & ~dis;
        wire pin = pin_s[i + 1];
        wire rise = pin & ~pin_prev;
        wire fall = ~pin & pin_prev;
        wire edge_hit = (edge_level[0] & rise) | (edge_level[1] & fall);
        wire use_p = buffered_mode_bit & sel_partner;
        wire [15:0] val_act = use_p ? val_all[16 * P +: 16] : val;
        wire hold_act = use_p ? hold_all[P] : cmp_hold;
        wire hi_take = avs_read_i & ~ack & (avs_address_i == A_HI) & ~mode_cmp;
        wire cap_evt = capture_mode & edge_hit & ~counter_halt & ~cap_hold & ~hi_take;
        wire cmp_evt = compare_mode & run & (cnt == val_act) & ~hold_act;
        wire ev = cap_evt | cmp_evt;
        wire wr_ctrl = wr_go & (avs_address_i == A_CTRL) & ~dis;
        wire rd_ctrl = rd_go & (avs_address_i == A_CTRL);
        wire wr_hi = wr_go & (avs_address_i == A_HI);
        wire wr_lo = wr_go & (avs_address_i == A_LO);

        assign ctrl_all[8 * i +: 8] = dis ? 8'h00 : {chan_event_flag, chan_irq_enable,
            buffered_mode_bit, unbuffered_mode_bit, edge_level, overflow_toggle_enable,
            full_duty_force};
        assign val_all[16 * i +: 16] = val;
        assign msb_all[i] = buffered_mode_bit;
        assign hold_all[i] = cmp_hold;
        assign chan_irq_o[i] = chan_event_flag & chan_irq_enable & ~dis;
        assign chan_pin_o[i] = out_lvl;
        assign chan_pin_oe_n_o[i] = ~compare_mode;
        assign chan_pin_timer_o[i] = el_on & ~dis;

        always @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                chan_event_flag <= 1'b0;
                chan_irq_enable <= 1'b0;
                buffered_mode_bit <= 1'b0;
                unbuffered_mode_bit <= 1'b0;
                edge_level <= 2'h0;
                overflow_toggle_enable <= 1'b0;
                full_duty_force <= 1'b0;
                val <= 16'h0000;
                cmp_hold <= 1'b0;
                cap_hold <= 1'b0;
                arm <= 1'b0;
                out_lvl <= 1'b1;
                pin_prev <= 1'b0;
                sel_partner <= 1'b0;
                partner_pending <= 1'b0;
            end else if (ce_i) begin
                pin_prev <= pin;
                if (wr_ctrl) begin
                    chan_irq_enable <= wdat[`SCTC_CH_IE];
                    buffered_mode_bit <= wdat[`SCTC_CH_MSB] & EVEN;
                    unbuffered_mode_bit <= wdat[`SCTC_CH_MSA];
                    edge_level <= wdat[`SCTC_CH_ELH:`SCTC_CH_ELL];
                    overflow_toggle_enable <= wdat[`SCTC_CH_TOV];
                    full_duty_force <= wdat[`SCTC_CH_MAX];
                end
                if (ev) begin
                    chan_event_flag <= 1'b1;
                    arm <= 1'b0;
                end else begin
                    if (wr_ctrl & ~wdat[`SCTC_CH_FLAG] & arm) begin
                        chan_event_flag <= 1'b0;
                    end
                    if (rd_ctrl & avs_readdata_o[`SCTC_CH_FLAG]) begin
                        arm <= 1'b1;
                    end else if (wr_ctrl) begin
                        arm <= 1'b0;
                    end
                end
                if (cap_evt) begin
                    val <= cnt;
                end else if (wr_hi) begin
                    val[15:8] <= wdat;
                end else if (wr_lo) begin
                    val[7:0] <= wdat;
                end
                if (wr_hi & mode_cmp) begin
                    cmp_hold <= 1'b1;
                end else if (wr_lo) begin
                    cmp_hold <= 1'b0;
                end
                // Reading the captured high byte freezes captures until low is read
                if (hi_take) begin
                    cap_hold <= 1'b1;
                end else if (rd_go & (avs_address_i == A_LO)) begin
                    cap_hold <= 1'b0;
                end
                if (~buffered_mode_bit) begin
                    sel_partner <= 1'b0;
                    partner_pending <= 1'b0;
                end else begin
                    if (wr_go & (avs_address_i == A_PLO)) begin
                        partner_pending <= 1'b1;
                    end else if (wr_lo) begin
                        partner_pending <= 1'b0;
                    end
                    if (ovf_evt) begin
                        sel_partner <= partner_pending;
                    end
                end
                if (~el_on) begin
                    out_lvl <= ~unbuffered_mode_bit;
                end else if (compare_mode & ovf_evt & overflow_toggle_enable) begin
                    // Overflow has priority; max duty holds the level high each period
                    out_lvl <= full_duty_force ? 1'b1 : ~out_lvl;
                end else if (cmp_evt & ~full_duty_force) begin
                    case (edge_level)
                        `SCTC_EL_TOGGLE: begin
                            out_lvl <= ~out_lvl;
                        end
                        `SCTC_EL_CLEAR: begin
                            out_lvl <= 1'b0;
                        end
                        `SCTC_EL_SET: begin
                            out_lvl <= 1'b1;
                        end
                        default: begin
                            out_lvl <= out_lvl;
                        end
                    endcase
                end
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Read data selection; unmapped addresses read zero

reg [3:0] j;

always @* begin
    rd_mux = 8'h00;
    case (avs_address_i)
        `SCTC_REG_TSC: begin
            // Counter reset bit always reads zero
            rd_mux = {overflow_flag, overflow_irq_enable, counter_halt, 2'b00,
                clock_divider_select};
        end
        `SCTC_REG_COUNT_HI: begin
            rd_mux = cnt[15:8];
        end
        `SCTC_REG_COUNT_LO: begin
            rd_mux = lo_latched ? lo_buf : cnt[7:0];
        end
        `SCTC_REG_LIMIT_HI: begin
            rd_mux = limit[15:8];
        end
        `SCTC_REG_LIMIT_LO: begin
            rd_mux = limit[7:0];
        end
        default: begin
            rd_mux = 8'h00;
        end
    endcase
    for (j = 4'h0; j < 4'h6; j = j + 4'h1) begin
        if (avs_address_i == `SCTC_REG_CHAN_CTRL0 + {2'b00, j}) begin
            rd_mux = ctrl_all[8 * j +: 8];
        end
        if (avs_address_i == `SCTC_REG_CHAN_VAL0 + {1'b0, j, 1'b0}) begin
            rd_mux = val_all[16 * j + 8 +: 8];
        end
        if (avs_address_i == `SCTC_REG_CHAN_VAL0 + {1'b0, j, 1'b1}) begin
            rd_mux = val_all[16 * j +: 8];
        end
    end
end

endmodule
`default_nettype wire

// ===== verif/sctc_checker.sv
// Concurrent checks on the six channel timer top: bus handshake, pin ownership, irq causes.
// Assumes ce_i held high; bound to every instance of sctc_top.
`timescale 1ns/1ns
`default_nettype none

module sctc_checker (
    // Clock and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Pins and requests
    input wire logic ext_clk_is_input_o,
    input wire logic [5:0] chan_pin_oe_n_o,
    input wire logic [5:0] chan_pin_timer_o,
    input wire logic ovf_irq_o,
    input wire logic [5:0] chan_irq_o
);
    logic done_wr;
    logic sel_wr;

    // A write counts only at the edge where it completes
    assign done_wr = avs_write_i && !avs_waitrequest_o;
    assign sel_wr = done_wr && avs_address_i == 6'h00;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    first_wait_a:
        assert property ((avs_read_i || avs_write_i) && !$past(avs_read_i || avs_write_i)
            |-> avs_waitrequest_o) else $error("request answered without a wait state");
    one_wait_a:
        assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i
            |=> !avs_waitrequest_o) else $error("wait state longer than one cycle");
    upper_zero_a:
        assert property (avs_readdata_o[31:8] == 24'h000000) else $error("read data upper bits set");
    rdata_hold_a:
        assert property ($changed(avs_readdata_o) |-> $past(avs_read_i))
        else $error("read data changed without a read");
    ext_rise_a:
        assert property ($rose(ext_clk_is_input_o) |-> $past(sel_wr && avs_writedata_i[2:0] == 3'h7))
        else $error("clock pin turned input without select write");
    ext_fall_a:
        assert property ($fell(ext_clk_is_input_o) |-> $past(sel_wr && avs_writedata_i[2:0] != 3'h7))
        else $error("clock pin released without select write");
    irq_fall_a:
        assert property (($fell(ovf_irq_o) || |($past(chan_irq_o) & ~chan_irq_o)) |-> $past(done_wr))
        else $error("interrupt request dropped without a write");
    owner_keep_a:
        assert property ($changed(chan_pin_timer_o) |-> $past(done_wr))
        else $error("pin ownership changed without a write");
    oe_owner_a:
        assert property ((~chan_pin_oe_n_o & ~chan_pin_timer_o) == 6'h00)
        else $error("pin driven while not owned by the timer");
endmodule

bind sctc_top sctc_checker chk_u (.clk_i, .rst_i, .ce_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .ext_clk_is_input_o,
    .chan_pin_oe_n_o, .chan_pin_timer_o, .ovf_irq_o, .chan_irq_o);

`default_nettype wire

// ===== verif/sctc_pin_model.sv
// Far side of the timer pins: capture sources and an external counter clock.
// Assumes the bench sets the idle levels and starts or stops the external clock.
`timescale 1ns/1ns
`default_nettype none

module sctc_pin_model (
    // Clock
    input wire logic clk_i,
    // Commands from the bench
    input wire logic [5:0] level_i,
    input wire logic ext_run_i,
    // Timer side
    input wire logic [5:0] chan_pin_o,
    input wire logic [5:0] chan_pin_oe_n_o,
    output logic [5:0] chan_pin_i,
    output logic ext_timer_clock_pin_i
);
    logic [1:0] div = 2'h0;
    logic tick = 1'b0;

    // The timer wins the wire where it drives, the far side elsewhere
    assign chan_pin_i = (chan_pin_o & ~chan_pin_oe_n_o) | (level_i & chan_pin_oe_n_o);
    assign ext_timer_clock_pin_i = tick;

    // An eighth of the bus rate, well under the bus/2 ceiling; still outside a run
    always @(posedge clk_i) begin
        div <= div + 2'h1;
        if (ext_run_i && div == 2'h3) begin
            tick <= ~tick;
        end
    end
endmodule

`default_nettype wire

// ===== verif/tb_sctc_top.sv
// Self-checking bench for the six channel timer, one task per scenario.
// Assumes the bound checker and the pin model; ce_i is held high throughout.
`timescale 1ns/1ns
`default_nettype none

module tb_sctc_top;
    logic clk_i, rst_i, ce_i, avs_read_i, avs_write_i, wreq, ext_pin, ext_in, ext_run, ovf_irq;
    logic [5:0] addr, chan_in, chan_out, oe_n, owned, chan_irq, level;
    logic [31:0] wdata, rdata;
    logic [7:0] r, h, l;
    int failures = 0;
    int compares = 0;
    int cycles = 0;

    sctc_top dut_u (.clk_i, .rst_i, .ce_i, .avs_address_i(addr), .avs_read_i, .avs_write_i,
        .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
        .ext_timer_clock_pin_i(ext_pin), .ext_clk_is_input_o(ext_in), .chan_pin_i(chan_in),
        .chan_pin_o(chan_out), .chan_pin_oe_n_o(oe_n), .chan_pin_timer_o(owned),
        .ovf_irq_o(ovf_irq), .chan_irq_o(chan_irq));
    sctc_pin_model pins_u (.clk_i, .level_i(level), .ext_run_i(ext_run), .chan_pin_o(chan_out),
        .chan_pin_oe_n_o(oe_n), .chan_pin_i(chan_in), .ext_timer_clock_pin_i(ext_pin));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Bus cycles hold the request until waitrequest is seen low at an edge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= {24'h000000, d};
        avs_write_i <= 1'b1;
        do @(posedge clk_i); while (wreq !== 1'b0);
        avs_write_i <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        avs_read_i <= 1'b1;
        do @(posedge clk_i); while (wreq !== 1'b0);
        d = rdata[7:0];
        avs_read_i <= 1'b0;
    endtask

    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        rd(a, r);
        chk(r, e);
    endtask

    task automatic settle;
        repeat (3) @(negedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic s_reset;
        rdc(6'h00, 8'h20);
        rdc(6'h01, 8'h00);
        rdc(6'h02, 8'h00);
        rdc(6'h03, 8'hFF);
        rdc(6'h04, 8'hFF);
        rdc(6'h05, 8'h00);
        wr(6'h01, 8'h5A);
        rdc(6'h01, 8'h00);
        rdc(6'h3F, 8'h00);
        chk(ovf_irq, 1'b0);
    endtask

    task automatic s_prescale;
        int e;
        for (int s = 0; s < 7; s++) begin
            wr(6'h00, 8'h30 | s[7:0]);
            rdc(6'h01, 8'h00);
            rdc(6'h02, 8'h00);
            wr(6'h00, s[7:0]);
            repeat (256) @(posedge clk_i);
            wr(6'h00, 8'h20 | s[7:0]);
            rd(6'h01, h);
            rd(6'h02, l);
            e = 259 >> s;
            chk({h, l} >= e - 2 && {h, l} <= e + 2, 1'b1);
        end
    endtask

    task automatic s_latch;
        logic [15:0] d;
        wr(6'h00, 8'h10);
        rdc(6'h00, 8'h00);
        rd(6'h01, h);
        rd(6'h02, l);
        chk({h, l} < 16'h0010, 1'b1);
        rd(6'h01, h);
        repeat (150) @(posedge clk_i);
        rd(6'h01, r);
        repeat (150) @(posedge clk_i);
        rd(6'h02, l);
        d = {h, l};
        rd(6'h01, h);
        rd(6'h02, l);
        d = {h, l} - d;
        chk(d > 16'h012C && d < 16'h0140, 1'b1);
    endtask

    task automatic s_overflow;
        wr(6'h00, 8'h70);
        wr(6'h03, 8'h00);
        wr(6'h04, 8'h10);
        wr(6'h03, 8'h00);
        wr(6'h00, 8'h40);
        repeat (60) @(posedge clk_i);
        chk(ovf_irq, 1'b0);
        rdc(6'h00, 8'h40);
        wr(6'h00, 8'h70);
        wr(6'h04, 8'h10);
        wr(6'h00, 8'h40);
        repeat (40) if (ovf_irq !== 1'b1) @(posedge clk_i);
        chk(ovf_irq, 1'b1);
        wr(6'h00, 8'hE0);
        rdc(6'h00, 8'hE0);
        wr(6'h00, 8'h20);
        rdc(6'h00, 8'h20);
        chk(ovf_irq, 1'b0);
    endtask

    task automatic s_capture;
        logic e;
        wr(6'h00, 8'h30);
        wr(6'h05, 8'h44);
        level[0] <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk(chan_irq[0], 1'b0);
        for (int c = 1; c < 4; c++) begin
            for (int f = 0; f < 2; f++) begin
                level[0] <= f[0];
                wr(6'h00, 8'h30);
                rd(6'h05, r);
                wr(6'h05, 8'h40 | c[7:0] << 2);
                wr(6'h00, 8'h00);
                level[0] <= ~f[0];
                repeat (8) @(posedge clk_i);
                e = c == 3 || (c == 1 && f == 0) || (c == 2 && f == 1);
                chk(chan_irq[0], e);
            end
        end
    endtask

    task automatic s_compare;
        wr(6'h0F, 8'h00);
        wr(6'h10, 8'h08);
        for (int c = 1; c < 4; c++) begin
            wr(6'h00, 8'h30);
            wr(6'h07, (c == 3) ? 8'h10 : 8'h00);
            wr(6'h07, 8'h10 | c[7:0] << 2);
            settle;
            chk(chan_out[2], c != 3);
            chk(oe_n[2], 1'b0);
            wr(6'h00, 8'h00);
            repeat (12) @(posedge clk_i);
            chk(chan_out[2], c == 3);
        end
    endtask

    task automatic s_toggle;
        wr(6'h00, 8'h30);
        rd(6'h07, r);
        wr(6'h07, 8'h10);
        wr(6'h07, 8'h14);
        wr(6'h0F, 8'h00);
        wr(6'h00, 8'h00);
        repeat (40) @(posedge clk_i);
        rdc(6'h07, 8'h14);
        chk(chan_out[2], 1'b0);
        wr(6'h00, 8'h30);
        wr(6'h07, 8'h10);
        wr(6'h07, 8'h1A);
        wr(6'h10, 8'h10);
        wr(6'h00, 8'h00);
        repeat (20) @(posedge clk_i);
        chk(chan_out[2], 1'b1);
    endtask

    task automatic s_buffered;
        wr(6'h00, 8'h30);
        wr(6'h06, 8'h04);
        settle;
        chk({owned[1], oe_n[1]}, 2'h3);
        wr(6'h05, 8'h28);
        settle;
        chk({owned[1], owned[0]}, 2'h1);
        rdc(6'h06, 8'h00);
    endtask

    task automatic s_ext;
        wr(6'h03, 8'hFF);
        wr(6'h04, 8'hFF);
        wr(6'h00, 8'h37);
        settle;
        chk(ext_in, 1'b1);
        wr(6'h00, 8'h07);
        ext_run <= 1'b1;
        repeat (160) @(posedge clk_i);
        ext_run <= 1'b0;
        wr(6'h00, 8'h27);
        rd(6'h01, h);
        rd(6'h02, l);
        chk({h, l} >= 16'h0013 && {h, l} <= 16'h0015, 1'b1);
        wr(6'h00, 8'h20);
        settle;
        chk(ext_in, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Whole run needs some 3000 cycles; the ceiling leaves ample margin
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop;
        end
    end

    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        addr = 6'h00;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        wdata = 32'h00000000;
        level = 6'h00;
        ext_run = 1'b0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        s_reset;
        s_prescale;
        s_latch;
        s_overflow;
        s_capture;
        s_compare;
        s_toggle;
        s_buffered;
        s_ext;
        report_and_stop;
    end
endmodule

`default_nettype wire
